// *** ipet_pkg.sv ***
// constants for the interrupt priority and external trigger block
package ipet_pkg;
  localparam int unsigned ipet_num_src = 11;
  localparam int unsigned ipet_vec_w = 4;
  localparam logic [7:0] ipet_timer_extirq_control_ofs = 8'h88;
  localparam logic [7:0] ipet_ipl_ofs = 8'hb8;
  localparam logic [7:0] ipet_iph_ofs = 8'hba;
  localparam logic [7:0] ipet_extended_priority_high_ofs = 8'hbb;
  localparam logic [7:0] ipet_eipl_ofs = 8'hbc;
  localparam logic [7:0] ipet_ext23_ofs = 8'hc0;
  localparam logic [7:0] ipet_ipl_mask = 8'h3f;
  localparam logic [7:0] ipet_iph_mask = 8'hff;
  localparam logic [7:0] ipet_eip_mask = 8'h07;
  localparam logic [7:0] ipet_ext23_mask = 8'h88;
  localparam logic [7:0] ipet_reg_rst = 8'h00;
  localparam int unsigned ipet_timer_extirq_control_ie1_bit = 3;
  localparam int unsigned ipet_timer_extirq_control_it1_bit = 2;
  localparam int unsigned ipet_timer_extirq_control_ie0_bit = 1;
  localparam int unsigned ipet_timer_extirq_control_it0_bit = 0;
  localparam int unsigned ipet_ext3_bit = 7;
  localparam int unsigned ipet_ext2_bit = 3;
  localparam logic [1:0] ipet_lvl_none = 2'h0;
  // vector numbers of the priority-register sources
  localparam logic [3:0] ipet_vec_ext2 = 4'h6;
  localparam logic [3:0] ipet_vec_ext3 = 4'h7;
  localparam logic [3:0] ipet_vec_spi = 4'h8;
  localparam logic [3:0] ipet_vec_wake = 4'h9;
  localparam logic [3:0] ipet_vec_bod = 4'ha;
  localparam logic [3:0] ipet_vec_ext0 = 4'h0;
  localparam logic [3:0] ipet_vec_ext1 = 4'h2;
  localparam logic [3:0] ipet_vec_none = 4'hf;
endpackage

// *** ipet_arbiter.sv ***
// priority arbiter: picks the winning source among requests
`timescale 1ns/1ns
module ipet_arbiter #(
  parameter int unsigned NSRC = 11
) (
  // request side
  input wire logic [NSRC-1:0] req,
  input wire logic [2*NSRC-1:0] lvl,
  // result
  output logic found,
  output logic [3:0] win_vec,
  output logic [1:0] win_lvl
);
  initial begin
    if (NSRC < 1 || NSRC > 15) $error("ipet_arbiter: NSRC out of range");
  end
  // R12: ascending vector order
  always_comb begin
    found = 1'b0;
    win_vec = 4'hf;
    win_lvl = 2'h0;
    // scan downward so the lowest vector wins ties, non-strict (>=) compare for level
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && (!found || lvl[2*i +: 2] >= win_lvl)) begin
        found = 1'b1;
        win_vec = 4'(i);
        win_lvl = lvl[2*i +: 2];
      end
    end
  end
endmodule // ipet_arbiter

// *** ipet_top.sv ***
// interrupt priority registers, external 0/1 trigger logic and arbitration
//
// How it works
// R1: low priority register holds one bit per basic source, bits 7:6 reserved.
// R2: high priority register pairs each bit; bits 7/6 serve external 3/2.
// R3: extended low register: brown-out bit 2, wake timer bit 1, spi bit 0.
// R4: extended high register pairs with extended low for those three sources.
// R5: both high priority registers reset to zero.
// R6: type select 0 means low level, 1 means falling edge.
// R7: edge mode sets a sticky flag, cleared by software or service entry.
// R8: level mode flag is the inverse of the active-low pin, unlatched.
// R9: four levels across eleven sources, each with flag and enable.
// R10: a routine is preempted only by a strictly higher level.
// R11: pins sampled once per machine cycle; high then low is an edge.
// R12: level is high:low bits, 11 highest; ties go to lowest vector.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module ipet_top
  import ipet_pkg::*;
#(
  parameter int unsigned MC_DIV = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external pins, active low
  input wire logic ext_irq0_pin_n,
  input wire logic ext_irq1_pin_n,
  // other sources: request flags and enables by vector number
  input wire logic [ipet_num_src-1:0] src_req,
  input wire logic [ipet_num_src-1:0] src_en,
  input wire logic global_en,
  // cpu core
  input wire logic svc_enter,
  input wire logic svc_return,
  output logic irq_pending,
  output logic [3:0] irq_vector,
  output logic [1:0] active_level,
  output logic in_service
);
  initial begin
    if (MC_DIV < 1 || MC_DIV > 255) $error("ipet_top: MC_DIV out of range");
  end

  logic [7:0] ipl_q, iph_q, eipl_q, extended_priority_high_q, ext23_q;
  logic it0_q, it1_q, ie0_edge_q, ie1_edge_q;
  logic [1:0] samp_q;
  logic [7:0] mc_cnt_q;
  logic [3:0] svc_vec_q;
  logic [1:0] act_lvl_q;
  logic act_q;
  logic rd_pend_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [3:0] vec_q;
  logic [1:0] lvl_q;

  // machine cycle tick
  wire mc_tick = (mc_cnt_q == 8'(MC_DIV - 1));

  // bus decode
  wire sel_timer_extirq_control = (avs_address == ipet_timer_extirq_control_ofs);
  wire sel_ipl = (avs_address == ipet_ipl_ofs);
  wire sel_iph = (avs_address == ipet_iph_ofs);
  wire sel_extended_priority_high = (avs_address == ipet_extended_priority_high_ofs);
  wire sel_eipl = (avs_address == ipet_eipl_ofs);
  wire sel_ext23 = (avs_address == ipet_ext23_ofs);
  wire wr = avs_write && !avs_waitrequest;
  wire [7:0] wd = avs_writedata[7:0];

  // R8: level flags
  wire ie0_lvl = !ext_irq0_pin_n;
  wire ie1_lvl = !ext_irq1_pin_n;
  // R6: type select chooses flag source
  wire ie0 = it0_q ? ie0_edge_q : ie0_lvl;
  wire ie1 = it1_q ? ie1_edge_q : ie1_lvl;

  // R11: edge is previous sample high, new sample low
  wire edge0 = mc_tick && samp_q[0] && ext_irq0_pin_n == 1'b0;
  wire edge1 = mc_tick && samp_q[1] && ext_irq1_pin_n == 1'b0;

  // service entry clears edge flags of the source served
  wire clr0_hw = svc_enter && irq_q && vec_q == ipet_vec_ext0;
  wire clr1_hw = svc_enter && irq_q && vec_q == ipet_vec_ext1;
  wire wr_timer_extirq_control = wr && sel_timer_extirq_control;

  wire [7:0] timer_extirq_control_rd = {4'h0, ie1, it1_q, ie0, it0_q};
  wire [7:0] rd_mux =
    sel_timer_extirq_control ? timer_extirq_control_rd :
    sel_ipl ? (ipl_q & ipet_ipl_mask) :
    sel_iph ? iph_q :
    sel_extended_priority_high ? (extended_priority_high_q & ipet_eip_mask) :
    sel_eipl ? (eipl_q & ipet_eip_mask) :
    sel_ext23 ? (ext23_q & ipet_ext23_mask) : 8'h00;

  // R12: level of each source as high:low
  function automatic logic [1:0] lvl_of(input logic h, input logic l);
    return {h, l};
  endfunction

  // R9: eleven sources, vectors 0..10
  logic [2*ipet_num_src-1:0] lvls;
  // R1: basic sources by vector number
  // R2: high bits paired at the same positions
  assign lvls[1:0] = lvl_of(iph_q[0], ipl_q[0]);
  assign lvls[3:2] = lvl_of(iph_q[1], ipl_q[1]);
  assign lvls[5:4] = lvl_of(iph_q[2], ipl_q[2]);
  assign lvls[7:6] = lvl_of(iph_q[3], ipl_q[3]);
  assign lvls[9:8] = lvl_of(iph_q[4], ipl_q[4]);
  assign lvls[11:10] = lvl_of(iph_q[5], ipl_q[5]);
  assign lvls[13:12] = lvl_of(iph_q[6], ext23_q[ipet_ext2_bit]);
  assign lvls[15:14] = lvl_of(iph_q[7], ext23_q[ipet_ext3_bit]);
  // R3: extended low bits
  // R4: extended high paired
  assign lvls[17:16] = lvl_of(extended_priority_high_q[0], eipl_q[0]);
  assign lvls[19:18] = lvl_of(extended_priority_high_q[1], eipl_q[1]);
  assign lvls[21:20] = lvl_of(extended_priority_high_q[2], eipl_q[2]);

  // external flags replace the caller's inputs at vectors 0 and 2
  logic [ipet_num_src-1:0] reqs;
  always_comb begin
    reqs = src_req;
    reqs[ipet_vec_ext0] = ie0;
    reqs[ipet_vec_ext1] = ie1;
    reqs = reqs & src_en & {ipet_num_src{global_en}};
  end

  logic found;
  logic [3:0] win_vec;
  logic [1:0] win_lvl;
  ipet_arbiter #(.NSRC(ipet_num_src)) u_arb (
    .req(reqs),
    .lvl(lvls),
    .found(found),
    .win_vec(win_vec),
    .win_lvl(win_lvl)
  );

  // R10: strictly higher level only
  wire can_take = found && (!act_q || win_lvl > act_lvl_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mc_cnt_q <= 8'h00;
      samp_q <= 2'h3;
    end else begin
      mc_cnt_q <= mc_tick ? 8'h00 : mc_cnt_q + 8'h01;
      if (mc_tick) begin
        samp_q <= {ext_irq1_pin_n, ext_irq0_pin_n};
      end
    end
  end

  // R5: high registers reset to zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ipl_q <= ipet_reg_rst;
      iph_q <= ipet_reg_rst;
      eipl_q <= ipet_reg_rst;
      extended_priority_high_q <= ipet_reg_rst;
      ext23_q <= ipet_reg_rst;
    end else if (wr) begin
      if (sel_ipl) ipl_q <= wd & ipet_ipl_mask;
      if (sel_iph) iph_q <= wd & ipet_iph_mask;
      if (sel_eipl) eipl_q <= wd & ipet_eip_mask;
      if (sel_extended_priority_high) extended_priority_high_q <= wd & ipet_eip_mask;
      if (sel_ext23) ext23_q <= wd & ipet_ext23_mask;
    end
  end

  // R7: sticky edge flags, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      it0_q <= 1'b0;
      it1_q <= 1'b0;
      ie0_edge_q <= 1'b0;
      ie1_edge_q <= 1'b0;
    end else begin
      if (wr_timer_extirq_control) begin
        it0_q <= wd[ipet_timer_extirq_control_it0_bit];
        it1_q <= wd[ipet_timer_extirq_control_it1_bit];
      end
      if (edge0) ie0_edge_q <= 1'b1;
      else if (clr0_hw) ie0_edge_q <= 1'b0;
      else if (wr_timer_extirq_control) ie0_edge_q <= wd[ipet_timer_extirq_control_ie0_bit];
      if (edge1) ie1_edge_q <= 1'b1;
      else if (clr1_hw) ie1_edge_q <= 1'b0;
      else if (wr_timer_extirq_control) ie1_edge_q <= wd[ipet_timer_extirq_control_ie1_bit];
    end
  end

  // one nesting slot in total is enough: a return unwinds one step
  // by going back to idle; deeper nesting is tracked by the core
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 1'b0;
      act_lvl_q <= ipet_lvl_none;
      svc_vec_q <= ipet_vec_none;
    end else if (svc_enter && irq_q) begin
      act_q <= 1'b1;
      act_lvl_q <= lvl_q;
      svc_vec_q <= vec_q;
    end else if (svc_return) begin
      act_q <= 1'b0;
      act_lvl_q <= ipet_lvl_none;
      svc_vec_q <= ipet_vec_none;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
      vec_q <= ipet_vec_none;
      lvl_q <= ipet_lvl_none;
    end else begin
      irq_q <= can_take;
      vec_q <= can_take ? win_vec : ipet_vec_none;
      // level kept with the offered vector, not the live winner
      lvl_q <= can_take ? win_lvl : ipet_lvl_none;
    end
  end

  // read takes one wait cycle so data comes from a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rd_pend_q <= avs_read && !rd_pend_q;
      if (avs_read && !rd_pend_q) rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign avs_waitrequest = avs_read && !rd_pend_q;
  assign avs_readdata = rdata_q;
  assign irq_pending = irq_q;
  assign irq_vector = vec_q;
  assign active_level = act_lvl_q;
  assign in_service = act_q;
endmodule // ipet_top

// *** ipet_assertions.sv ***
// assertions for the priority and trigger block
`timescale 1ns/1ns
module ipet_chk (
  // clock and bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // core side
  input wire logic svc_enter,
  input wire logic svc_return,
  input wire logic irq_pending,
  input wire logic [3:0] irq_vector,
  input wire logic in_service
);
  import ipet_pkg::*;
  wire rd_ok = avs_read && !avs_waitrequest;
  wire mapped = avs_address inside {8'h88, 8'hb8, 8'hba, 8'hbb, 8'hbc, 8'hc0};
  wire extended_priority_low = avs_address inside {ipet_eipl_ofs, ipet_extended_priority_high_ofs};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wn; avs_write |-> !avs_waitrequest; endproperty
  a_wn: assert property (p_wn) else $error("write stalled");
  property p_rw; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_rw: assert property (p_rw) else $error("read timing");
  property p_rh; rd_ok |-> avs_readdata[31:8] == 24'h0; endproperty
  a_rh: assert property (p_rh) else $error("upper bits set");
  property p_ru; rd_ok && !mapped |-> avs_readdata == 32'h0; endproperty
  a_ru: assert property (p_ru) else $error("unmapped data");
  property p_rr; rd_ok && avs_address == ipet_ipl_ofs |->
    avs_readdata[7:6] == 2'h0; endproperty
  a_rr: assert property (p_rr) else $error("reserved bits set");
  property p_re; rd_ok && extended_priority_low |-> avs_readdata[7:3] == 5'h0; endproperty
  a_re: assert property (p_re) else $error("extended reserved");
  property p_en; svc_enter && irq_pending |=> in_service; endproperty
  a_en: assert property (p_en) else $error("no service entry");
  property p_rt; svc_return && !svc_enter |=> !in_service; endproperty
  a_rt: assert property (p_rt) else $error("no return");
  property p_vc; irq_pending |-> irq_vector != ipet_vec_none; endproperty
  a_vc: assert property (p_vc) else $error("pending without vector");
  c_rd: cover property (rd_ok && mapped);
  c_en: cover property (svc_enter);
  c_rt: cover property (svc_return);
endmodule // ipet_chk
bind ipet_top ipet_chk chk_i (.clk, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .svc_enter, .svc_return,
  .irq_pending, .irq_vector, .in_service);

// *** ipet_core_model.sv ***
// cpu core stand-in: takes the offered vector and returns on command
`timescale 1ns/1ns
module ipet_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // block side and bench control
  input wire logic irq_pending,
  input wire logic take,
  input wire logic done,
  output logic svc_enter,
  output logic svc_return
);
  logic busy_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      svc_enter <= 1'b0;
      svc_return <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      svc_enter <= !busy_q && !svc_enter && take && irq_pending;
      svc_return <= busy_q && done && !svc_return;
      busy_q <= svc_enter || (busy_q && !svc_return);
    end
  end
endmodule // ipet_core_model

// *** tb.sv ***
// self-checking bench for the priority and trigger block
`timescale 1ns/1ns
module tb;
  import ipet_pkg::*;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, take = 0, done = 0, wq;
  logic pend, enter, ret, insvc;
  logic [1:0] pin = 2'h3;
  logic [1:0] alvl;
  logic [3:0] vec;
  logic [7:0] adr = 0;
  logic [10:0] req = 0;
  logic [31:0] wd = 0, rdata;
  logic [7:0] q[$];
  int n_fail = 0, compares = 0, seed = 33;
  logic [7:0] ofs[4] = '{8'hb8, 8'hba, 8'hbb, 8'hbc};
  logic [7:0] msk[4] = '{8'h3f, 8'hff, 8'h07, 8'h07};
  always #5 clk = ~clk;
  ipet_top #(.MC_DIV(2)) dut (.clk, .rst_b, .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(wq), .ext_irq0_pin_n(pin[0]),
    .ext_irq1_pin_n(pin[1]), .src_req(req), .src_en(11'h7ff),
    .global_en(1'b1), .svc_enter(enter), .svc_return(ret),
    .irq_pending(pend), .irq_vector(vec), .active_level(alvl),
    .in_service(insvc));
  ipet_core_model core (.clk, .rst_b, .irq_pending(pend), .take, .done,
    .svc_enter(enter), .svc_return(ret));
  task chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hold the request until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, d, e);
    int n;
    logic ok;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    if (!w) q.push_back(e);
    n = 0;
    ok = 1'b0;
    // look at waitrequest mid-cycle, the next rising edge then accepts
    while (!ok && n < 40) begin
      @(negedge clk);
      ok = (wq === 1'b0);
      @(posedge clk);
      n++;
    end
    if (!ok) begin
      n_fail++;
      finish_test();
    end
    rd <= 0;
    wr <= 0;
  endtask
  task w8(input logic [7:0] a, d);
    bus(1, a, d, 0);
  endtask
  task r8(input logic [7:0] a, e);
    bus(0, a, 0, e);
  endtask
  task svc(input logic v);
    int n;
    n = 0;
    while (insvc !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      n_fail++;
      finish_test();
    end
  endtask
  task waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // settled values just before the accepting edge
  always @(negedge clk)
    if (rd === 1'b1 && wq === 1'b0 && q.size() > 0)
      chk("rdata", {24'h0, q.pop_front()}, rdata);
  initial begin
    logic [7:0] d;
    waitc(16);
    rst_b <= 1;
    r8(ipet_iph_ofs, 0);
    r8(ipet_extended_priority_high_ofs, 0);
    r8(8'h90, 0);
    foreach (ofs[i]) begin
      d = 8'($random(seed));
      w8(ofs[i], d);
      r8(ofs[i], d & msk[i]);
      w8(ofs[i], 0);
    end
    $display("register test done");
    w8(ipet_timer_extirq_control_ofs, 0);
    pin <= 2'h0;
    waitc(4);
    r8(ipet_timer_extirq_control_ofs, 8'h0a);
    pin <= 2'h3;
    waitc(4);
    r8(ipet_timer_extirq_control_ofs, 0);
    w8(ipet_timer_extirq_control_ofs, 8'h05);
    // pins hold each level longer than one machine cycle
    waitc(6);
    pin <= 2'h0;
    waitc(6);
    pin <= 2'h3;
    waitc(6);
    r8(ipet_timer_extirq_control_ofs, 8'h0f);
    chk("vec", ipet_vec_ext0, vec);
    take <= 1;
    svc(1);
    take <= 0;
    r8(ipet_timer_extirq_control_ofs, 8'h0d);
    chk("pend", 0, pend);
    w8(ipet_timer_extirq_control_ofs, 8'h05);
    r8(ipet_timer_extirq_control_ofs, 8'h05);
    done <= 1;
    svc(0);
    done <= 0;
    $display("trigger test done");
    w8(ipet_ipl_ofs, 8'h08);
    w8(ipet_iph_ofs, 8'h08);
    req <= 11'h00a;
    waitc(3);
    chk("vec", 3, vec);
    take <= 1;
    svc(1);
    take <= 0;
    req <= 11'h022;
    waitc(3);
    chk("lvl", 3, alvl);
    chk("pend", 0, pend);
    done <= 1;
    svc(0);
    done <= 0;
    waitc(3);
    chk("vec", 1, vec);
    $display("priority test done");
    finish_test();
  end
endmodule // tb
